// >>> motor_pwm_map.svh
// register offsets, field positions and reset values for the motor pwm core
`ifndef MOTOR_PWM_MAP_SVH
`define MOTOR_PWM_MAP_SVH
`define OFS_CTRL0 8'h00
`define OFS_CTRL1 8'h04
`define OFS_PERIOD 8'h08
`define OFS_MODE 8'h0C
`define OFS_CHCTL0 8'h10
`define OFS_DUTY0 8'h20
`define CTRL0_PRE_LO 0
`define CTRL0_DITHER_ENABLE 2
`define CTRL0_OVF_FLAG 7
`define CTRL1_RECIRCULATION_SELECT 0
`define CTRL1_OVF_IE 7
`define MODE_WAIT 0
`define MODE_STOP 1
`define MODE_SWAI 2
`define CH_ALIGN_LO 0
`define CH_DELAY_LO 4
`define CH_OUTMODE 6
`define CH_SIGN 7
`define CH_RESET 8'h00
`endif

// >>> motor_pwm_pkg.sv
// types shared by the motor pwm core
package motor_pwm_pkg;
  typedef enum logic [1:0] {ALIGN_OFF, ALIGN_LEFT, ALIGN_RIGHT, ALIGN_CENTER} align_e;
endpackage

// >>> pwm_channel.sv
// one pwm channel: compare, dither, saturation, falling-edge delay, output mapping
`timescale 1ns/10ps
`include "motor_pwm_map.svh"
module pwm_channel
  import motor_pwm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic run,
  input wire logic halt,
  input wire logic [10:0] cnt,
  input wire logic half2,
  input wire logic frame_end,
  input wire logic dither,
  input wire logic recirculation_select,
  input wire logic [10:0] period,
  input wire logic [10:0] duty,
  input wire logic [7:0] chctl,
  output logic out_m,
  output logic out_p,
  output logic out_en
);
  import motor_pwm_pkg::*;
  logic [1:0] mode_w;
  logic [1:0] dly_w;
  logic [10:0] cmp_w;
  logic [10:0] ccnt_w;
  logic [10:0] half_w;
  logic sat_w;
  logic raw_w;
  logic lvl_w;
  logic act_reg;
  logic [2:0] hist_reg;
  logic dly_out_w;
  logic pwm_w;
  logic en_reg;
  assign mode_w = chctl[`CH_ALIGN_LO+:2];
  assign dly_w = chctl[`CH_DELAY_LO+:2];
  assign half_w = dither ? {1'b0, period[10:1]} : period;
  // dither: second half compares duty+1 when duty_bit_zero is set
  assign cmp_w = dither ? ({1'b0, duty[10:1]} + {10'h000, half2 & duty[0]}) : duty; // [R2] [R3] [R18] [R21]
  // right: counter reversed so the low part sits at the end of the frame
  assign ccnt_w = (mode_w == ALIGN_RIGHT) ? (half_w - 11'h001 - cnt) : cnt; // [R21]
  assign sat_w = (duty >= period); // [R6] [R7]
  assign raw_w = sat_w ? 1'b0 : (ccnt_w >= cmp_w); // [R2] [R4]
  // recirculation flips the active level; the delay then works on the pin level itself
  assign lvl_w = recirculation_select ? ~raw_w : raw_w; // [R2] [R6]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_reg <= 1'b0;
      hist_reg <= 3'h0;
      en_reg <= 1'b0;
    end else begin
      if (tick) begin
        act_reg <= lvl_w;
        hist_reg <= {hist_reg[1:0], act_reg};
      end
      // enable changes only at overflow, without delay; a cleared period stops the
      // counter, so it must drop the enable at once rather than wait for a tick
      if ((tick && frame_end) || !run) begin
        en_reg <= run && (mode_w != ALIGN_OFF); // [R11] [R20]
      end
    end
  end
  // high-to-low transitions wait dly counter ticks, rising edges pass at once
  assign dly_out_w = act_reg | (dly_w > 2'h0 & hist_reg[0]) | (dly_w > 2'h1 & hist_reg[1])
    | (dly_w > 2'h2 & hist_reg[2]); // [R10]
  assign pwm_w = dly_out_w;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_m <= 1'b0;
      out_p <= 1'b0;
      out_en <= 1'b1;
    end else begin
      out_en <= ~en_reg; // [R15]
      if (!en_reg || halt) begin // [R12] [R14]
        out_m <= ~recirculation_select;
        out_p <= ~recirculation_select;
      end else if (!chctl[`CH_OUTMODE]) begin
        out_m <= pwm_w;
        out_p <= pwm_w;
      end else if (chctl[`CH_SIGN] ^ recirculation_select) begin
        out_m <= ~recirculation_select; // [R19]
        out_p <= pwm_w;
      end else begin
        out_m <= pwm_w;
        out_p <= ~recirculation_select; // [R19]
      end
    end
  end
  sat_level_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
    (tick && en_reg && !halt && sat_w && !recirculation_select
    && (!chctl[`CH_OUTMODE] || !chctl[`CH_SIGN])) [*6] |-> !out_m)
    else $error("saturated duty not constant");
endmodule

// >>> motor_pwm_dither_core.sv
// motor pwm core: ahb-lite registers, prescaler, frame counter, channels
//
// Operation
// [R1] with dither on, period bit zero is forced zero and reads zero
// [R2] left dither: low until counter hits duty upper bits, high till half end
// [R3] second half compares duty upper bits plus duty bit zero
// [R4] dither pattern repeats each full period, four edges per period
// [R5] software changes dither only while controller disabled
// [R6] duty at or above period gives constant level set by recirculation
// [R7] duty fraction equals duty over period when valid
// [R8] counter clock is bus clock divided by 1, 2, 4 or 8
// [R9] frequency is counter rate over period times alignment factor
// [R10] falling output edges delayed 0 to 3 counter ticks per channel
// [R11] disabled channel stops at next overflow ignoring delay
// [R12] wait with stop-in-wait halts clocks, pins inactive, registers kept
// [R13] wait without stop-in-wait keeps pwm running
// [R14] stop halts clocks, pins inactive, registers kept
// [R15] reset releases pins and restores register reset values
// [R16] interrupt requested when enable set and frame completes
// [R17] interrupt cleared by clearing enable or writing one to flag
// [R18] without dither full eleven-bit duty and period used
// [R19] full bridge static terminal high without recirculation, low with it
// [R20] nonzero period enables controller, zero period disables it
// [R21] right and center dither alternate duty and duty plus one likewise
`timescale 1ns/10ps
`include "motor_pwm_map.svh"
module motor_pwm_dither_core
  import motor_pwm_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [CHANNELS-1:0] pwm_m,
  output logic [CHANNELS-1:0] pwm_p,
  output logic [CHANNELS-1:0] pwm_oe_n,
  output logic irq
);
  import motor_pwm_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [10:0] period_reg;
  logic [2:0] mode_reg;
  logic [7:0] chctl_reg [CHANNELS];
  logic [10:0] duty_reg [CHANNELS];
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic flag_reg;
  logic [31:0] rdata_next;
  logic addr_ph_w;
  logic dither_w;
  logic [10:0] period_eff_w;
  logic halt_w;
  logic run_w;
  logic frame_end_w;
  logic [2:0] pre_reg;
  logic tick_w;
  logic [10:0] cnt_reg;
  logic half2_reg;
  logic up_reg;
  logic [10:0] half_w;
  logic [1:0] amode_w;
  logic [CHANNELS-1:0] pm_w;
  logic [CHANNELS-1:0] pp_w;
  logic [CHANNELS-1:0] pe_w;
  logic clr_flag_w;
  assign addr_ph_w = hsel && hready && htrans[1];
  assign dither_w = ctrl0_reg[`CTRL0_DITHER_ENABLE];
  assign period_eff_w = dither_w ? {period_reg[10:1], 1'b0} : period_reg; // [R1]
  assign run_w = (period_eff_w != 11'h000); // [R20]
  // clocks freeze in stop, and in wait only when stop-in-wait is set
  assign halt_w = mode_reg[`MODE_STOP] || (mode_reg[`MODE_WAIT] && mode_reg[`MODE_SWAI]); // [R12] [R13] [R14]
  assign tick_w = !halt_w && run_w && (pre_reg == ((3'h1 << ctrl0_reg[`CTRL0_PRE_LO+:2]) - 3'h1)); // [R8]
  assign amode_w = chctl_reg[0][`CH_ALIGN_LO+:2];
  // dither splits the frame into two halves of period/2 each
  assign half_w = dither_w ? {1'b0, period_eff_w[10:1]} : period_eff_w; // [R4] [R9]
  assign frame_end_w = tick_w && (dither_w ? half2_reg : 1'b1) &&
    ((amode_w == ALIGN_CENTER) ? (!up_reg && cnt_reg == 11'h001) : (cnt_reg == half_w - 11'h001)); // [R9]
  assign clr_flag_w = wr_pend_reg && wr_addr_reg == `OFS_CTRL0 && hwdata[`CTRL0_OVF_FLAG];
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg <= 3'h0;
      cnt_reg <= 11'h000;
      half2_reg <= 1'b0;
      up_reg <= 1'b1;
    end else if (!run_w) begin
      pre_reg <= 3'h0;
      cnt_reg <= 11'h000;
      half2_reg <= 1'b0;
      up_reg <= 1'b1;
    end else if (!halt_w) begin
      pre_reg <= tick_w ? 3'h0 : pre_reg + 3'h1;
      if (tick_w) begin
        if (amode_w == ALIGN_CENTER) begin
          if (up_reg && cnt_reg == half_w - 11'h001) begin
            up_reg <= 1'b0;
          end else if (!up_reg && cnt_reg == 11'h001) begin
            up_reg <= 1'b1;
            half2_reg <= dither_w & ~half2_reg; // [R21]
          end
          cnt_reg <= (up_reg && cnt_reg != half_w - 11'h001) || (!up_reg && cnt_reg == 11'h001)
            ? cnt_reg + 11'h001 : cnt_reg - 11'h001;
        end else if (cnt_reg >= half_w - 11'h001) begin
          cnt_reg <= 11'h000;
          half2_reg <= dither_w & ~half2_reg; // [R3] [R4]
        end else begin
          cnt_reg <= cnt_reg + 11'h001;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // register writes land in the data phase; a flag write of one clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ph_w && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0_reg <= 8'h00; // [R15]
      ctrl1_reg <= 8'h00;
      period_reg <= 11'h000;
      mode_reg <= 3'h0;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        `OFS_CTRL0: ctrl0_reg <= {1'b0, hwdata[6:0]};
        `OFS_CTRL1: ctrl1_reg <= hwdata[7:0];
        `OFS_PERIOD: period_reg <= hwdata[10:0];
        `OFS_MODE: mode_reg <= hwdata[2:0];
        default: ctrl0_reg <= ctrl0_reg;
      endcase
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          chctl_reg[gi] <= `CH_RESET;
          duty_reg[gi] <= 11'h000;
        end else if (wr_pend_reg && wr_addr_reg == `OFS_CHCTL0 + 8'(gi * 4)) begin
          chctl_reg[gi] <= hwdata[7:0];
        end else if (wr_pend_reg && wr_addr_reg == `OFS_DUTY0 + 8'(gi * 4)) begin
          duty_reg[gi] <= hwdata[10:0];
        end
      end
      pwm_channel u_ch (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick_w),
        .run(run_w),
        .halt(halt_w),
        .cnt(cnt_reg),
        .half2(half2_reg),
        .frame_end(frame_end_w),
        .dither(dither_w),
        .recirculation_select(ctrl1_reg[`CTRL1_RECIRCULATION_SELECT]),
        .period(period_eff_w),
        .duty(duty_reg[gi]),
        .chctl(chctl_reg[gi]),
        .out_m(pm_w[gi]),
        .out_p(pp_w[gi]),
        .out_en(pe_w[gi])
      );
    end
  endgenerate
  assign pwm_m = pm_w;
  assign pwm_p = pp_w;
  assign pwm_oe_n = pe_w;
  ////////////////////////////////////////////////////////////////////////
  // set beats clear when a frame ends in the clearing cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (frame_end_w) begin
        flag_reg <= 1'b1; // [R16]
      end else if (clr_flag_w) begin
        flag_reg <= 1'b0; // [R17]
      end
      irq <= (frame_end_w || (flag_reg && !clr_flag_w)) && ctrl1_reg[`CTRL1_OVF_IE]; // [R16] [R17]
    end
  end
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (haddr[7:0])
      `OFS_CTRL0: rdata_next = {24'h000000, flag_reg, ctrl0_reg[6:0]};
      `OFS_CTRL1: rdata_next = {24'h000000, ctrl1_reg};
      `OFS_PERIOD: rdata_next = {21'h000000, period_eff_w}; // [R1]
      `OFS_MODE: rdata_next = {29'h00000000, mode_reg};
      default: begin
        for (int i = 0; i < CHANNELS; i++) begin
          if (haddr[7:0] == `OFS_CHCTL0 + 8'(i * 4)) rdata_next = {24'h000000, chctl_reg[i]};
          if (haddr[7:0] == `OFS_DUTY0 + 8'(i * 4)) rdata_next = {21'h000000, duty_reg[i]};
        end
      end
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (addr_ph_w && !hwrite) begin
        hrdata <= rdata_next;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  period_lsb_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
    dither_w |-> !period_eff_w[0])
    else $error("period lsb not forced in dither");
  rd_period_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
    (addr_ph_w && !hwrite && haddr[7:0] == `OFS_PERIOD && dither_w) |=> !hrdata[0])
    else $error("period lsb read back as one");
  zero_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R20]
    !run_w |=> cnt_reg == 11'h000)
    else $error("counter runs with zero period");
  run_decode_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R20]
    run_w == ((period_reg[10:1] != 10'h000) || (!dither_w && period_reg[0])))
    else $error("controller enable does not follow period");
  release_idle_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R20]
    !run_w |=> ##1 (pwm_oe_n == {CHANNELS{1'b1}}))
    else $error("pins driven with zero period");
  period_wr_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R20]
    (wr_pend_reg && wr_addr_reg == `OFS_PERIOD) |=> period_reg == $past(hwdata[10:0]))
    else $error("period write lost");
  halt_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R14] [R12]
    (halt_w && run_w) |=> $stable(cnt_reg))
    else $error("counter moved while halted");
  halt_level_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R12] [R14]
    halt_w |=> (pwm_m == {CHANNELS{!$past(ctrl1_reg[`CTRL1_RECIRCULATION_SELECT])}}
    && pwm_p == {CHANNELS{!$past(ctrl1_reg[`CTRL1_RECIRCULATION_SELECT])}}))
    else $error("pins not inactive while halted");
  regs_kept_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R12] [R14]
    (halt_w && !wr_pend_reg) |=> ($stable(ctrl0_reg) && $stable(ctrl1_reg) && $stable(period_reg)))
    else $error("register changed while halted");
  mode_wr_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R12] [R13] [R14]
    (wr_pend_reg && wr_addr_reg == `OFS_MODE) |=> mode_reg == $past(hwdata[2:0]))
    else $error("mode write lost");
  wait_run_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    (mode_reg[`MODE_WAIT] && !mode_reg[`MODE_SWAI] && !mode_reg[`MODE_STOP]) |-> !halt_w)
    else $error("halted in wait without stop-in-wait");
  presc_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
    (tick_w && !wr_pend_reg && ctrl0_reg[`CTRL0_PRE_LO+:2] != 2'h0) |=> !tick_w)
    else $error("prescaler ticks on consecutive cycles");
  pre_restart_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
    tick_w |=> pre_reg == 3'h0)
    else $error("prescaler not restarted after tick");
  left_step_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
    (tick_w && amode_w == ALIGN_LEFT && cnt_reg < half_w - 11'h001)
    |=> cnt_reg == $past(cnt_reg) + 11'h001)
    else $error("counter did not step");
  left_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R2] [R4]
    (tick_w && amode_w == ALIGN_LEFT && cnt_reg == half_w - 11'h001) |=> cnt_reg == 11'h000)
    else $error("counter did not wrap at half end");
  half_flip_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R3] [R4]
    (tick_w && dither_w && amode_w == ALIGN_LEFT && cnt_reg == half_w - 11'h001 && run_w)
    |=> half2_reg != $past(half2_reg))
    else $error("dither half did not alternate");
  duty_wr_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
    (wr_pend_reg && wr_addr_reg == `OFS_DUTY0) |=> duty_reg[0] == $past(hwdata[10:0]))
    else $error("duty write lost");
  irq_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    (frame_end_w && ctrl1_reg[`CTRL1_OVF_IE]) |=> irq)
    else $error("no irq at frame end");
  flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    frame_end_w |=> flag_reg)
    else $error("overflow flag not set at frame end");
  ctrl1_wr_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    (wr_pend_reg && wr_addr_reg == `OFS_CTRL1) |=> ctrl1_reg == $past(hwdata[7:0]))
    else $error("control 1 write lost");
  irq_clr_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R17]
    !ctrl1_reg[`CTRL1_OVF_IE] |=> !irq)
    else $error("irq with enable cleared");
  flag_clr_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R17]
    (clr_flag_w && !frame_end_w) |=> !flag_reg)
    else $error("overflow flag not cleared");
  irq_drop_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R17]
    (clr_flag_w && !frame_end_w) |=> !irq)
    else $error("irq stays after flag clear");
  resp_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");
endmodule

// >>> hbridge_model.sv
// h-bridge transistor model: resolves each motor pin from the core's drive
`timescale 1ns/10ps
module hbridge_model #(
  parameter int CHANNELS = 2
) (
  input wire logic hclk,
  input wire logic [CHANNELS-1:0] pwm_m,
  input wire logic [CHANNELS-1:0] pwm_p,
  input wire logic [CHANNELS-1:0] pwm_oe_n,
  output logic [CHANNELS-1:0] pin_m,
  output logic [CHANNELS-1:0] pin_p
);
  // a released pin has no pull, so it wanders; a stale level never passes for a drive
  logic [CHANNELS-1:0] float_reg = '0;
  always @(posedge hclk) begin
    float_reg <= ~float_reg;
  end
  assign pin_m = (~pwm_oe_n & pwm_m) | (pwm_oe_n & float_reg);
  assign pin_p = (~pwm_oe_n & pwm_p) | (pwm_oe_n & float_reg);
endmodule

// >>> tb.sv
// self-checking testbench for the motor pwm core
`timescale 1ns/10ps
`include "motor_pwm_map.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %0t got %0h expected %0h", $time, (a), (e)); end end
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [1:0] pwm_m, pwm_p, pwm_oe_n, pin_m, pin_p;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int lm, lp, e, l1;
  // columns: recirculation_select, prescale, duty, mode, low on m, low on p (-1 skip), edges
  localparam int T[8][7] = '{'{0, 0, 7, 0, 70, 0, 40}, '{0, 0, 6, 0, 60, 0, 40},
    '{0, 0, 20, 0, 200, 0, 0}, '{0, 1, 7, 0, 70, 0, 20}, '{0, 0, 7, 1, 70, 0, 40},
    '{0, 0, 7, 5, 0, 0, 0}, '{0, 0, 7, 2, 0, 0, 0}, '{1, 0, 7, 0, 200, 130, 40}};
  motor_pwm_dither_core #(.CHANNELS(2)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pwm_m(pwm_m), .pwm_p(pwm_p), .pwm_oe_n(pwm_oe_n), .irq(irq));
  hbridge_model #(.CHANNELS(2)) bridge (.hclk(hclk), .pwm_m(pwm_m), .pwm_p(pwm_p),
    .pwm_oe_n(pwm_oe_n), .pin_m(pin_m), .pin_p(pin_p));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, x)
  endtask
  // counts over 200 cycles: ten frames at full rate, so edge counts are exact
  task automatic measure();
    logic pm, pp;
    lm = 0;
    lp = 0;
    e = 0;
    l1 = 0;
    pm = pin_m[0];
    pp = pin_p[0];
    repeat (200) begin
      @(posedge hclk);
      lm += int'(pin_m[0] === 1'b0);
      lp += int'(pin_p[0] === 1'b0);
      l1 += int'(pin_m[1] === 1'b0);
      e += int'(pin_m[0] !== pm) + int'(pin_p[0] !== pp);
      pm = pin_m[0];
      pp = pin_p[0];
    end
  endtask
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 100) begin
      @(posedge hclk);
      k++;
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK(pwm_oe_n, 2'h3)
    `CHK(irq, 1'b0)
    rd(`OFS_CTRL0, 32'h0);
    rd(`OFS_CTRL1, 32'h0);
    rd(`OFS_PERIOD, 32'h0);
    rd(`OFS_CHCTL0, 32'h0);
    rd(`OFS_DUTY0, 32'h0);
    rd(8'hFC, 32'h0);
    wr(`OFS_CTRL0, 32'h04);
    wr(`OFS_PERIOD, 32'hC9);
    rd(`OFS_PERIOD, 32'hC8);
    wr(`OFS_PERIOD, 32'h0);
    // channel 0 full bridge left; channel 1 the same with three ticks of delay
    wr(`OFS_CHCTL0, 32'h41);
    wr(`OFS_CHCTL0 + 8'h04, 32'h71);
    wr(`OFS_DUTY0 + 8'h04, 32'h0F);
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_PERIOD, 32'h0);
      wr(`OFS_CTRL0, 32'(T[i][1]) | 32'h04);
      wr(`OFS_CTRL1, 32'(T[i][0]));
      wr(`OFS_DUTY0, 32'(T[i][2]));
      wr(`OFS_MODE, 32'h0);
      wr(`OFS_PERIOD, 32'h14);
      repeat (100) @(posedge hclk);
      wr(`OFS_MODE, 32'(T[i][3]));
      // let the pins settle into a new system mode before counting edges
      repeat (4) @(posedge hclk);
      measure();
      if (T[i][4] >= 0) `CHK(lm, T[i][4])
      if (T[i][5] >= 0) `CHK(lp, T[i][5])
      `CHK(e, T[i][6])
      if (i == 0) `CHK(l1, 90)
    end
    wr(`OFS_CTRL1, 32'h81);
    wait_irq();
    `CHK(irq, 1'b1)
    rd(`OFS_CTRL0, 32'h84);
    wr(`OFS_PERIOD, 32'h0);
    repeat (50) @(posedge hclk);
    wr(`OFS_CTRL0, 32'h84);
    repeat (3) @(posedge hclk);
    `CHK(irq, 1'b0)
    wr(`OFS_PERIOD, 32'h14);
    wait_irq();
    `CHK(irq, 1'b1)
    wr(`OFS_CTRL1, 32'h01);
    repeat (3) @(posedge hclk);
    `CHK(irq, 1'b0)
    wrap_up();
  end
endmodule
